// *** inc/rx_sigpro_pkg.sv ***
// package for the receive signal-processing configuration registers
// assumes a classic wishbone slave with 32-bit data and byte addressing
package rx_sigpro_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] RATE_IDX = 6'h1a;
    localparam logic [5:0] CARD_IDX = 6'h1b;
    localparam logic [5:0] CTRL_IDX = 6'h20;
    localparam logic [5:0] STAT_IDX = 6'h21;
    localparam int         ADR_W    = 8;

    // field positions in the card-mode register
    localparam int FRAMING_LSB = 29;
    localparam int TAPS_LSB    = 26;
    localparam int EDGE_LSB    = 13;
    localparam int BIT_LSB     = 0;
    localparam int TH_W        = 13;

    // field positions in the control and status registers
    localparam int AUTO_EN_BIT  = 0;
    localparam int CARD_MODE_BIT = 1;
    localparam int SEEN_BIT     = 0;
    localparam int RSVD_BIT     = 1;
    localparam int PROTO_LSB    = 2;

    // receive rate codes
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [2:0] RATE_106   = 3'h4;
    localparam logic [2:0] RATE_212   = 3'h5;
    localparam logic [2:0] RATE_424   = 3'h6;
    localparam logic [2:0] RATE_848   = 3'h7;

    // card-mode framing codes
    localparam logic [1:0] FRAME_TYPE_A = 2'h0;
    localparam logic [1:0] FRAME_PEER   = 2'h1;
    localparam logic [7:0] SYNC_BYTE    = 8'hf0;

    // values after reset
    localparam logic [31:0] CARD_RESET = 32'h0000_0000;
    localparam logic [1:0]  CTRL_RESET = 2'h0;

    // protocol reported by the mode detector
    typedef enum logic [1:0] {
        PROTO_TYPE_A = 2'h0,
        PROTO_TYPE_B = 2'h1,
        PROTO_C212   = 2'h2,
        PROTO_C424   = 2'h3
    } proto_t;

    // card-mode settings handed to the demodulator
    typedef struct packed {
        logic [1:0]      framing;
        logic            sync_required;
        logic [7:0]      sync_byte;
        logic [5:0]      filter_taps;
        logic [TH_W-1:0] edge_decision_threshold;
        logic [TH_W-1:0] bit_decision_threshold;
    } card_cfg_t;

endpackage

// *** rtl/rx_rx_rate_config_regs.sv ***
// receive signal-processing configuration registers behind a wishbone slave
// assumes wishbone classic cycles; detector pulses are synchronous to clk_i
//
// Summary of operation
// [R1] rate codes 100..111 give 106..848 kBd, reset 000
// [R2] rate msb ignored in card mode
// [R3] detector overwrites rate field when auto enabled
// [R4] detector loads 100 for A/B, 101/110 otherwise
// [R5] framing bits 30:29, 00b means type A
// [R6] framing 01b means peer framing with 0xF0 sync
// [R7] detector writes framing field when auto enabled
// [R8] tap field 28:26 selects filter length
// [R9] bits 25:13 hold edge decision threshold
// [R10] bits 12:0 hold bit decision threshold
// [R11] software avoids reserved rate codes 000..011
//
// Implementation choice: register access over Wishbone.
module rx_rx_rate_config_regs
    import rx_sigpro_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             mode_detect_valid_i,
    input  wire proto_t           mode_detect_proto_i,
    output logic      [2:0]       rx_symbol_rate_sel_o,
    output logic      [1:0]       card_rate_sel_o,
    output logic                  rate_reserved_o,
    output logic                  auto_detect_en_o,
    output logic                  card_mode_o,
    output card_cfg_t             card_cfg_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // merge write data into a register under byte enables
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // byte address of a register index
    function automatic logic [ADR_W-1:0] byte_addr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    // filter length for each tap selection code
    function automatic logic [5:0] taps_of(input logic [2:0] sel);
        logic [5:0] t;
        t = 6'h04;
        case (sel)
            3'h0: t = 6'h04;
            3'h1: t = 6'h06;
            3'h2: t = 6'h08;
            3'h3: t = 6'h08;
            3'h4: t = 6'h10;
            3'h5: t = 6'h12;
            3'h6: t = 6'h18;
            3'h7: t = 6'h20;
            default: t = 6'h04;
        endcase
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [2:0]  rate_q;
    logic [31:0] card_q;
    logic [31:0] card_d;
    logic [1:0]  ctrl_q;
    logic        seen_q;
    proto_t      proto_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        bus_req;
    logic        wr_en;
    logic        det_take;
    logic [2:0]  det_rate;
    logic [1:0]  det_frame;
    logic        hit_rate;
    logic        hit_card;
    logic        hit_ctrl;
    logic        hit_stat;
    logic [31:0] rate_word;
    logic [31:0] card_word;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    // a new request is taken only while no ack is pending
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en   = bus_req & wb_we_i;

    // address decode of the four words
    always_comb
    begin
        hit_rate = 1'b0;
        hit_card = 1'b0;
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        if (wb_adr_i == byte_addr(RATE_IDX))
        begin
            hit_rate = 1'b1;
        end
        else if (wb_adr_i == byte_addr(CARD_IDX))
        begin
            hit_card = 1'b1;
        end
        else if (wb_adr_i == byte_addr(CTRL_IDX))
        begin
            hit_ctrl = 1'b1;
        end
        else if (wb_adr_i == byte_addr(STAT_IDX))
        begin
            hit_stat = 1'b1;
        end
    end

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= bus_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode detector

    // detector results count only while auto detection is on
    assign det_take = mode_detect_valid_i & ctrl_q[AUTO_EN_BIT]; // [R3] [R7]

    // rate and framing for the detected protocol
    always_comb
    begin
        det_rate  = RATE_106;
        det_frame = FRAME_TYPE_A;
        case (mode_detect_proto_i)
            PROTO_TYPE_A:
            begin
                det_rate  = RATE_106; // [R4]
                det_frame = FRAME_TYPE_A; // [R7]
            end
            PROTO_TYPE_B:
            begin
                det_rate  = RATE_106; // [R4]
                det_frame = FRAME_TYPE_A;
            end
            PROTO_C212:
            begin
                det_rate  = RATE_212; // [R4]
                det_frame = FRAME_PEER; // [R7]
            end
            PROTO_C424:
            begin
                det_rate  = RATE_424; // [R4]
                det_frame = FRAME_PEER;
            end
            default:
            begin
                det_rate  = RATE_106;
                det_frame = FRAME_TYPE_A;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // receive rate; the detector wins over a software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rate_q <= RATE_RESET; // [R1]
        end
        else if (det_take)
        begin
            rate_q <= det_rate; // [R3]
        end
        else if (wr_en && hit_rate && wb_sel_i[0])
        begin
            rate_q <= wb_dat_i[2:0]; // [R1]
        end
    end

    // card-mode word after a software write, bit 31 kept at zero
    always_comb
    begin
        card_d = card_q;
        if (wr_en && hit_card)
        begin
            card_d = merge_bytes(card_q, wb_dat_i, wb_sel_i);
        end
        if (det_take)
        begin
            card_d[FRAMING_LSB +: 2] = det_frame; // [R7]
        end
        card_d[31] = 1'b0;
    end

    // framing, taps and the two thresholds
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            card_q <= CARD_RESET;
        end
        else
        begin
            card_q <= card_d; // [R5] [R8] [R9] [R10]
        end
    end

    // control: auto detection enable and card/reader mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (wr_en && hit_ctrl && wb_sel_i[0])
        begin
            ctrl_q <= wb_dat_i[1:0];
        end
    end

    // sticky detection flag, write one to clear; a new detection wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seen_q  <= 1'b0;
            proto_q <= PROTO_TYPE_A;
        end
        else if (det_take)
        begin
            seen_q  <= 1'b1;
            proto_q <= mode_detect_proto_i;
        end
        else if (wr_en && hit_stat && wb_sel_i[0] && wb_dat_i[SEEN_BIT])
        begin
            seen_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    // register words with reserved bits at zero
    assign rate_word = {29'h0000_0000, rate_q};
    assign card_word = {1'b0, card_q[30:0]};
    assign ctrl_word = {30'h0000_0000, ctrl_q};
    assign stat_word = {28'h000_0000, proto_q, rate_reserved_o, seen_q};

    // read multiplexer; unmapped words read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_rate)
        begin
            rd_mux = rate_word;
        end
        else if (hit_card)
        begin
            rd_mux = card_word;
        end
        else if (hit_ctrl)
        begin
            rd_mux = ctrl_word;
        end
        else if (hit_stat)
        begin
            rd_mux = stat_word;
        end
    end

    // read data captured with the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_q <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            rdat_q <= rd_mux;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // outputs to the receive path

    // rate as seen by the reader and the card demodulator
    assign rx_symbol_rate_sel_o = rate_q; // [R1]
    assign card_rate_sel_o      = rate_q[1:0]; // [R2]
    // reserved codes only exist in reader mode since card mode drops the msb
    assign rate_reserved_o      = ~ctrl_q[CARD_MODE_BIT] & ~rate_q[2]; // [R2] [R11]
    assign auto_detect_en_o     = ctrl_q[AUTO_EN_BIT];
    assign card_mode_o          = ctrl_q[CARD_MODE_BIT];

    // card-mode settings, all held in flip-flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            card_cfg_o <= '0;
        end
        else
        begin
            card_cfg_o.framing       <= card_d[FRAMING_LSB +: 2]; // [R5]
            card_cfg_o.sync_required <= card_d[FRAMING_LSB +: 2] == FRAME_PEER; // [R6]
            card_cfg_o.sync_byte     <= (card_d[FRAMING_LSB +: 2] == FRAME_PEER)
                                        ? SYNC_BYTE : 8'h00; // [R6]
            card_cfg_o.filter_taps   <= taps_of(card_d[TAPS_LSB +: 3]); // [R8]
            card_cfg_o.edge_decision_threshold <= card_d[EDGE_LSB +: TH_W]; // [R9]
            card_cfg_o.bit_decision_threshold  <= card_d[BIT_LSB +: TH_W]; // [R10]
        end
    end

endmodule

// *** verification/rx_rx_rate_config_regs_assertions.sv ***
// assertions on the receive configuration register block
// sees only the top module ports; bound to it at the foot of this file
module rx_rx_rate_config_regs_assertions
    import rx_sigpro_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic             wb_ack_o,
    input wire logic             mode_detect_valid_i,
    input wire proto_t           mode_detect_proto_i,
    input wire logic [2:0]       rx_symbol_rate_sel_o,
    input wire logic [1:0]       card_rate_sel_o,
    input wire logic             rate_reserved_o,
    input wire logic             auto_detect_en_o,
    input wire logic             card_mode_o,
    input wire card_cfg_t        card_cfg_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////////
    // request taken, detector taken, software write to the rate register
    logic take;
    logic det;
    logic wr_rate;
    assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign det     = mode_detect_valid_i && auto_detect_en_o;
    assign wr_rate = take && wb_we_i && wb_adr_i == 8'h68 && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////////
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_card_rate_low: assert property (card_rate_sel_o == rx_symbol_rate_sel_o[1:0])
        else $error("card rate not the low rate bits");
    a_rate_reserved: assert property (
        rate_reserved_o == (!card_mode_o && !rx_symbol_rate_sel_o[2]))
        else $error("reserved rate flag wrong");
    a_detect_rate: assert property (det |=> rx_symbol_rate_sel_o ==
        ($past(mode_detect_proto_i) == PROTO_C424 ? RATE_424 :
         $past(mode_detect_proto_i) == PROTO_C212 ? RATE_212 : RATE_106))
        else $error("detector rate code wrong");
    a_detect_framing: assert property (det |=> card_cfg_o.framing ==
        ($past(mode_detect_proto_i) >= PROTO_C212 ? FRAME_PEER : FRAME_TYPE_A))
        else $error("detector framing wrong");
    a_peer_sync: assert property (
        card_cfg_o.sync_required == (card_cfg_o.framing == FRAME_PEER) &&
        card_cfg_o.sync_byte == (card_cfg_o.framing == FRAME_PEER ? SYNC_BYTE : 8'h00))
        else $error("sync byte settings wrong");
    a_rate_holds: assert property (!det && !wr_rate |=> $stable(rx_symbol_rate_sel_o))
        else $error("rate changed without cause");

    // main scenarios
    c_detect_424: cover property (det && mode_detect_proto_i == PROTO_C424);
    c_rate_write: cover property (wr_rate);
    c_auto_off: cover property (mode_detect_valid_i && !auto_detect_en_o);
endmodule

bind rx_rx_rate_config_regs rx_rx_rate_config_regs_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
    .mode_detect_valid_i(mode_detect_valid_i), .mode_detect_proto_i(mode_detect_proto_i),
    .rx_symbol_rate_sel_o(rx_symbol_rate_sel_o), .card_rate_sel_o(card_rate_sel_o),
    .rate_reserved_o(rate_reserved_o), .auto_detect_en_o(auto_detect_en_o),
    .card_mode_o(card_mode_o), .card_cfg_o(card_cfg_o));

// *** verification/tb.sv ***
// self-checking bench for the receive configuration registers
// drives the wishbone port and the detector inputs itself
`define CHECK(got, want) \
    begin comparisons++; if ((got) !== (want)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module tb
    import rx_sigpro_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        det_v = 1'b0;
    proto_t      det_p = PROTO_TYPE_A;
    logic [2:0]  rate_o;
    logic [1:0]  crate_o;
    logic        rsv_o;
    logic        aen_o;
    logic        cm_o;
    card_cfg_t   cfg_o;
    int          failures = 0;
    int          comparisons = 0;
    logic [31:0] exp_q[$];
    logic [31:0] expected;
    logic [31:0] seed = 32'h3e;

    rx_rx_rate_config_regs u_rx_rx_rate_config_regs (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .mode_detect_valid_i(det_v),
        .mode_detect_proto_i(det_p), .rx_symbol_rate_sel_o(rate_o),
        .card_rate_sel_o(crate_o), .rate_reserved_o(rsv_o), .auto_detect_en_o(aen_o),
        .card_mode_o(cm_o), .card_cfg_o(cfg_o));

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic conclude();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one classic cycle, held until ack is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1)
        begin
            failures++;
            conclude();
        end
        cyc <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    // one detector pulse, outputs looked at once settled
    task automatic detect(input proto_t p);
        @(posedge clk_i);
        det_v <= 1'b1;
        det_p <= p;
        @(posedge clk_i);
        det_v <= 1'b0;
        @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // compares each read answer with the oldest note
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 && we === 1'b0)
        begin
            expected = exp_q.pop_front();
            `CHECK(dat_o, expected)
        end
    end

    // main sequence
    initial
    begin
        logic [31:0] w;
        static logic [5:0] taps [8] = '{6'd4, 6'd6, 6'd8, 6'd8, 6'd16, 6'd18, 6'd24, 6'd32};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h68, {29'h0, RATE_RESET});
        rd(8'h6c, CARD_RESET);
        rd(8'h00, 32'h0);
        `CHECK(cfg_o.filter_taps, 6'd4)
        $display("test reset values done");
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, 8'h68, {xs() & 32'hffff_fff8} | 32'(c), 4'h1);
            rd(8'h68, 32'(c));
            `CHECK(crate_o, 2'(c))
            `CHECK(rsv_o, 1'(c < 4))
        end
        $display("test rate codes done");
        for (int t = 0; t < 8; t++)
        begin
            w = xs();
            w[30:26] = {1'b0, 1'(t), 3'(t)};
            bus(1'b1, 8'h6c, w, 4'hf);
            rd(8'h6c, {1'b0, w[30:0]});
            `CHECK(cfg_o.filter_taps, taps[t])
            `CHECK(cfg_o.sync_byte, t[0] ? SYNC_BYTE : 8'h00)
            `CHECK(cfg_o.edge_decision_threshold, w[25:13])
            `CHECK(cfg_o.bit_decision_threshold, w[12:0])
        end
        bus(1'b1, 8'h6c, 32'hffff_ffff, 4'h1);
        rd(8'h6c, {1'b0, w[30:8], 8'hff});
        $display("test card register done");
        // reserved code in reader mode is flagged, then hidden once card mode is on
        bus(1'b1, 8'h68, 32'h0, 4'h1);
        `CHECK(rsv_o, 1'b1)
        bus(1'b1, 8'h80, 32'h3, 4'h1);
        `CHECK(rsv_o, 1'b0)
        `CHECK(aen_o, 1'b1)
        `CHECK(cm_o, 1'b1)
        for (int p = 0; p < 4; p++)
        begin
            detect(proto_t'(p));
            `CHECK(rate_o, p == 3 ? RATE_424 : p == 2 ? RATE_212 : RATE_106)
            `CHECK(cfg_o.framing, p > 1 ? FRAME_PEER : FRAME_TYPE_A)
        end
        rd(8'h84, 32'hd);
        bus(1'b1, 8'h84, 32'h1, 4'h1);
        rd(8'h84, 32'hc);
        bus(1'b1, 8'h80, 32'h2, 4'h1);
        `CHECK(aen_o, 1'b0)
        `CHECK(cm_o, 1'b1)
        detect(PROTO_TYPE_A);
        `CHECK(rate_o, RATE_424)
        bus(1'b1, 8'h00, 32'hffff_ffff, 4'hf);
        rd(8'h00, 32'h0);
        $display("test detector done");
        repeat (2) @(posedge clk_i);
        conclude();
    end
endmodule
